/* File: sfwm_host.sv */
`timescale 1ns/1ps

module sfwm_host #(
  parameter logic [6:0] DEV_ADDR = sfwm_pkg::DEV_ADDR_DEFAULT
) (
  output logic scl,
  output logic sda_low,
  input logic sda_line
);
  logic [7:0] rd [0:7];
  logic ack_ok;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    ack_ok = 1'b1;
  end

  // Data changes only 25 ns into the 100 ns low phase, 75 ns before the clock rises
  task automatic put_bit(input logic b);
    #25 sda_low = ~b;
    #75 scl = 1'b1;
    #100 scl = 1'b0;
  endtask

  task automatic get_bit(output logic b);
    #25 sda_low = 1'b0;
    #75 scl = 1'b1;
    #50 b = sda_line;
    #50 scl = 1'b0;
  endtask

  task automatic start_cond();
    #50 sda_low = 1'b1;
    #100 scl = 1'b0;
  endtask

  task automatic restart_cond();
    #25 sda_low = 1'b0;
    #75 scl = 1'b1;
    #100 sda_low = 1'b1;
    #100 scl = 1'b0;
  endtask

  task automatic stop_cond();
    #25 sda_low = 1'b1;
    #75 scl = 1'b1;
    #100 sda_low = 1'b0;
    #100;
  endtask

  task automatic put_byte(input logic [7:0] v);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(b);
    ack_ok = ack_ok & ~b;
  endtask

  task automatic get_byte(output logic [7:0] v, input logic last);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      v[i] = b;
    end
    put_bit(last);
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
    start_cond();
    put_byte({DEV_ADDR, 1'b0});
    put_byte(ptr);
    put_byte(val);
    stop_cond();
  endtask

  task automatic rd_burst(input logic [7:0] ptr, input int n);
    start_cond();
    put_byte({DEV_ADDR, 1'b0});
    put_byte(ptr);
    restart_cond();
    put_byte({DEV_ADDR, 1'b1});
    for (int i = 0; i < n; i++) get_byte(rd[i], i == n - 1);
    stop_cond();
  endtask
endmodule

/* File: sfwm_pkg.sv */
package sfwm_pkg;

  // Register map
  localparam logic [7:0] ADDR_DR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_OUT_FIRST = 8'h01;
  localparam logic [7:0] ADDR_OUT_LAST = 8'h05;
  localparam logic [7:0] ADDR_BUF_STATUS = 8'h0d;
  localparam logic [7:0] ADDR_BUF_READ = 8'h0e;
  localparam logic [7:0] ADDR_BUF_SETUP = 8'h0f;

  // Setup and status field layout
  localparam int MODE_LSB = 6;
  localparam int MODE_W = 2;
  localparam int MARK_W = 6;
  localparam int COUNT_W = 6;
  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Overflow policy codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_CIRC = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [1:0] MODE_UNUSED = 2'h3;

  // Sample record
  localparam int BYTE_W = 8;
  localparam int SAMPLE_W = 40;
  localparam int SAMPLE_DEPTH = 32;
  localparam logic [2:0] LAST_BYTE_IDX = 3'h4;

  // Serial link
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Arbitrary bus address, not taken from any real part
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

  typedef enum logic [6:0] {
    SFWM_IDLE = 7'h01,
    SFWM_ADDR = 7'h02,
    SFWM_ADDR_ACK = 7'h04,
    SFWM_WRITE = 7'h08,
    SFWM_WACK = 7'h10,
    SFWM_READ = 7'h20,
    SFWM_RACK = 7'h40
  } sfwm_state_t;

endpackage

/* File: sfwm_top.sv */
// Function
// - Six-bit count of stored samples; zero means empty and is reset value.
// - Status flags follow their cause; status read clears buffer event bit.
// - Overflow flag stays set while the buffer remains overflowed.
// - Level-mark flag shows when count exceeds the threshold.
// - Count equal to threshold raises level-mark flag and event.
// - At most 32 five-byte samples, read pressure high/mid/low, temperature high/low.
// - When enabled, read port also served at output address 01h.
// - When enabled, output addresses 02h to 05h read as 00h.
// - New samples keep being stored during host read transactions.
// - Each read byte is oldest data; a sample is removed after its fifth byte, count drops per sample.
// - Count above threshold does not block new samples.
// - Samples are stored at the acquisition rate tick.
// - Policy 00 disabled at reset, 11 unused, 01 circular overwrite oldest.
// - Policy 10 stops storing once overflowed.
// - Flush on disable and on standby to active transition.
// - Writing disabled code clears overflow, level-mark flag and count.
// - Overflow flag asserts when count reaches 32.
// - Threshold zero suppresses the level-mark flag; zero at reset.
// - Setup register accepts writes in active mode.
// - Event bit set by overflow or count equal to threshold.
// - Direct change between circular and stop codes is not taken.
// - Disabled buffer: 00h to 05h auto-increment status then outputs.
`timescale 1ns/1ps

module sfwm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input logic clk,
  input logic arst_n,
  input logic flush,
  input logic in_valid,
  output logic in_ready,
  input logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
      $error("sfwm_fifo needs DEPTH of two or more and WIDTH of one or more");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [LW-1:0] lvl;
  } sfwm_fifo_state_t;

  sfwm_fifo_state_t q;
  sfwm_fifo_state_t d;
  logic push;
  logic pop;

  // Full still accepts when the head leaves in the same cycle
  assign in_ready = (q.lvl != LW'(DEPTH)) || out_ready;
  assign out_valid = (q.lvl != '0);
  assign out_data = q.mem[q.rp];
  assign level = q.lvl;
  assign push = in_valid && in_ready;
  assign pop = out_ready && out_valid;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
    end
    if (push && !pop) begin
      d.lvl = q.lvl + 1'b1;
    end else if (pop && !push) begin
      d.lvl = q.lvl - 1'b1;
    end
    // Contents are left stale; only the pointers and level matter
    if (flush) begin
      d.wp = '0;
      d.rp = '0;
      d.lvl = '0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

module sfwm_top #(
  parameter int SAMPLE_DEPTH = sfwm_pkg::SAMPLE_DEPTH,
  parameter logic [6:0] DEV_ADDR = sfwm_pkg::DEV_ADDR_DEFAULT
) (
  input logic clk,
  input logic arst_n,
  input logic scl_pin,
  input logic sda_pin,
  output logic sda_level,
  output logic sda_oe,
  input logic sample_valid,
  output logic sample_ready,
  input logic [sfwm_pkg::SAMPLE_W-1:0] sample_data,
  input logic [7:0] live_status,
  input logic [sfwm_pkg::SAMPLE_W-1:0] live_data,
  input logic active_mode,
  output logic buffer_event_pending,
  output logic [sfwm_pkg::COUNT_W-1:0] stored_sample_count
);
  localparam int COUNT_W = sfwm_pkg::COUNT_W;
  localparam int SW = sfwm_pkg::SAMPLE_W;
  localparam int BW = sfwm_pkg::BYTE_W;
  localparam int LW = $clog2(SAMPLE_DEPTH + 1);
  localparam logic [COUNT_W-1:0] FULL_COUNT = COUNT_W'(SAMPLE_DEPTH);

  generate
    if (SAMPLE_DEPTH < 2 || LW > COUNT_W) begin : g_bad
      $error("sfwm_top SAMPLE_DEPTH must fit the six-bit count field");
    end
  endgenerate

  typedef struct packed {
    sfwm_pkg::sfwm_state_t st;
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic [3:0] bits;
    logic [7:0] shift;
    logic rw;
    logic first;
    logic nack;
    logic oe;
    logic [7:0] ptr;
    logic [7:0] setup;
    logic [2:0] bidx;
    logic ovf;
    logic pend;
    logic cond_p;
    logic act_p;
  } sfwm_top_state_t;

  sfwm_top_state_t q;
  sfwm_top_state_t d;

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [1:0] mode;
  logic [1:0] new_mode;
  logic [5:0] mark;
  logic enabled;
  logic flush;
  logic [COUNT_W-1:0] count;
  logic [LW-1:0] fifo_level;
  logic [SW-1:0] head;
  logic head_valid;
  logic fifo_in_ready;
  logic push_req;
  logic host_pop;
  logic ovw_pop;
  logic port_hit;
  logic ld;
  logic wr;
  logic mark_flag;
  logic mark_hit;
  logic cond;
  logic ev_set;
  logic [7:0] rdata;
  logic [7:0] status_byte;
  logic [7:0] ptr_next;
  logic [7:0] head_byte;
  logic [7:0] live_byte;

  assign scl_rise = q.scl_s && !q.scl_p;
  assign scl_fall = !q.scl_s && q.scl_p;
  assign start_cond = q.scl_s && q.scl_p && !q.sda_s && q.sda_p;
  assign stop_cond = q.scl_s && q.scl_p && q.sda_s && !q.sda_p;

  assign mode = q.setup[sfwm_pkg::MODE_LSB +: sfwm_pkg::MODE_W];
  assign new_mode = q.shift[sfwm_pkg::MODE_LSB +: sfwm_pkg::MODE_W];
  assign mark = q.setup[sfwm_pkg::MARK_W-1:0];
  assign enabled = (mode != sfwm_pkg::MODE_OFF);
  assign flush = !enabled || (active_mode && !q.act_p);
  assign count = COUNT_W'(fifo_level);

  assign push_req = sample_valid && enabled && !flush;
  assign ovw_pop = push_req && (mode == sfwm_pkg::MODE_CIRC) && (count == FULL_COUNT)
                   && !host_pop;
  assign port_hit = enabled && (q.ptr == sfwm_pkg::ADDR_OUT_FIRST
                    || q.ptr == sfwm_pkg::ADDR_BUF_READ);
  assign host_pop = ld && port_hit && head_valid && (q.bidx == sfwm_pkg::LAST_BYTE_IDX);
  assign sample_ready = fifo_in_ready;

  assign mark_flag = (mark != '0) && (count >= mark);
  assign mark_hit = (mark != '0) && (count == mark);
  assign status_byte = {q.ovf, mark_flag, count};
  assign cond = q.ovf || mark_hit;
  assign ev_set = cond && !q.cond_p;

  // pressure high first, temperature low last
  assign head_byte = head[(sfwm_pkg::LAST_BYTE_IDX - q.bidx) * BW +: BW];
  assign live_byte = live_data[3'(sfwm_pkg::ADDR_OUT_LAST - q.ptr) * BW +: BW];

  always_comb begin
    rdata = sfwm_pkg::BYTE_ZERO;
    if (q.ptr == sfwm_pkg::ADDR_BUF_STATUS) begin
      rdata = status_byte;
    end else if (q.ptr == sfwm_pkg::ADDR_BUF_SETUP) begin
      rdata = q.setup;
    end else if (port_hit) begin
      rdata = head_valid ? head_byte : sfwm_pkg::BYTE_ZERO;
    end else if (q.ptr == sfwm_pkg::ADDR_DR_STATUS) begin
      rdata = live_status;
    end else if (!enabled && q.ptr >= sfwm_pkg::ADDR_OUT_FIRST
                 && q.ptr <= sfwm_pkg::ADDR_OUT_LAST) begin
      rdata = live_byte;
    end
  end

  always_comb begin
    ptr_next = q.ptr + 8'h01;
    // burst stays on the read port
    if (port_hit) begin
      ptr_next = q.ptr;
    end else if (!enabled && q.ptr == sfwm_pkg::ADDR_OUT_LAST) begin
      ptr_next = sfwm_pkg::ADDR_DR_STATUS;
    end
  end

  always_comb begin
    d = q;
    ld = 1'b0;
    wr = 1'b0;
    d.scl_m = scl_pin;
    d.scl_s = q.scl_m;
    d.scl_p = q.scl_s;
    d.sda_m = sda_pin;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;
    d.act_p = active_mode;
    if (start_cond) begin
      d.st = sfwm_pkg::SFWM_ADDR;
      d.bits = '0;
      d.oe = 1'b0;
    end else if (stop_cond) begin
      d.st = sfwm_pkg::SFWM_IDLE;
      d.oe = 1'b0;
    end else begin
      unique case (q.st)
        sfwm_pkg::SFWM_IDLE: begin
          d.oe = 1'b0;
        end
        sfwm_pkg::SFWM_ADDR, sfwm_pkg::SFWM_WRITE: begin
          if (scl_rise) begin
            d.shift = {q.shift[6:0], q.sda_s};
            d.bits = q.bits + 4'h1;
          end else if (scl_fall && q.bits == sfwm_pkg::BITS_PER_BYTE) begin
            if (q.st == sfwm_pkg::SFWM_WRITE) begin
              d.st = sfwm_pkg::SFWM_WACK;
              d.oe = 1'b1;
              d.first = 1'b0;
              if (q.first) begin
                d.ptr = q.shift;
              end else begin
                wr = 1'b1;
                d.ptr = ptr_next;
              end
            end else if (q.shift[7:1] == DEV_ADDR) begin
              d.st = sfwm_pkg::SFWM_ADDR_ACK;
              d.rw = q.shift[0];
              d.oe = 1'b1;
            end else begin
              d.st = sfwm_pkg::SFWM_IDLE;
            end
          end
        end
        sfwm_pkg::SFWM_ADDR_ACK: begin
          if (scl_fall) begin
            d.bits = '0;
            if (q.rw) begin
              ld = 1'b1;
              d.st = sfwm_pkg::SFWM_READ;
              d.shift = rdata;
              d.oe = !rdata[7];
            end else begin
              d.st = sfwm_pkg::SFWM_WRITE;
              d.first = 1'b1;
              d.oe = 1'b0;
            end
          end
        end
        sfwm_pkg::SFWM_WACK: begin
          if (scl_fall) begin
            d.st = sfwm_pkg::SFWM_WRITE;
            d.bits = '0;
            d.oe = 1'b0;
          end
        end
        sfwm_pkg::SFWM_READ: begin
          if (scl_rise) begin
            d.bits = q.bits + 4'h1;
          end else if (scl_fall) begin
            if (q.bits == sfwm_pkg::BITS_PER_BYTE) begin
              d.st = sfwm_pkg::SFWM_RACK;
              d.oe = 1'b0;
            end else begin
              d.shift = {q.shift[6:0], 1'b0};
              d.oe = !q.shift[6];
            end
          end
        end
        sfwm_pkg::SFWM_RACK: begin
          if (scl_rise) begin
            d.nack = q.sda_s;
          end else if (scl_fall) begin
            if (q.nack) begin
              d.st = sfwm_pkg::SFWM_IDLE;
            end else begin
              ld = 1'b1;
              d.st = sfwm_pkg::SFWM_READ;
              d.bits = '0;
              d.shift = rdata;
              d.oe = !rdata[7];
            end
          end
        end
        default: begin
          d.st = sfwm_pkg::SFWM_IDLE;
          d.oe = 1'b0;
        end
      endcase
    end
    if (ld) begin
      d.ptr = ptr_next;
      if (port_hit && head_valid) begin
        d.bidx = (q.bidx == sfwm_pkg::LAST_BYTE_IDX) ? 3'h0 : q.bidx + 3'h1;
      end
    end
    if (wr && q.ptr == sfwm_pkg::ADDR_BUF_SETUP) begin
      d.setup[sfwm_pkg::MARK_W-1:0] = q.shift[sfwm_pkg::MARK_W-1:0];
      if (new_mode != sfwm_pkg::MODE_UNUSED
          && (mode == sfwm_pkg::MODE_OFF || new_mode == sfwm_pkg::MODE_OFF)) begin
        d.setup[sfwm_pkg::MODE_LSB +: sfwm_pkg::MODE_W] = new_mode;
      end
    end
    // Overwritten head takes any partly read record with it
    if (ovw_pop || flush) begin
      d.bidx = 3'h0;
    end
    d.ovf = !flush && (count == FULL_COUNT);
    d.cond_p = cond;
    d.pend = ev_set || (q.pend && !(ld && q.ptr == sfwm_pkg::ADDR_BUF_STATUS));
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.st <= sfwm_pkg::SFWM_IDLE;
      q.scl_m <= 1'b1;
      q.scl_s <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.sda_p <= 1'b1;
      q.setup <= sfwm_pkg::SETUP_RESET;
    end else begin
      q <= d;
    end
  end

  sfwm_fifo #(
    .WIDTH(SW),
    .DEPTH(SAMPLE_DEPTH)
  ) u_store (
    .clk(clk),
    .arst_n(arst_n),
    .flush(flush),
    .in_valid(push_req),
    .in_ready(fifo_in_ready),
    .in_data(sample_data),
    .out_valid(head_valid),
    .out_ready(host_pop || ovw_pop),
    .out_data(head),
    .level(fifo_level)
  );

  assign sda_level = 1'b0;
  assign sda_oe = q.oe;
  assign buffer_event_pending = q.pend;
  assign stored_sample_count = count;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_full_push;
    count == FULL_COUNT && sample_valid && !flush && !host_pop;
  endsequence

  sequence s_mark_reach;
    count != mark ##1 (mark != '0 && count == mark && !q.ovf);
  endsequence

  a_count_max: assert property (count <= FULL_COUNT)
    else $error("sample count above depth");
  a_ovf_hold: assert property (enabled && !flush && count == FULL_COUNT |=> q.ovf)
    else $error("overflow flag not set while full");
  a_mark_above: assert property (mark != '0 && count > mark |-> status_byte[6])
    else $error("level-mark flag missing above threshold");
  a_mark_event: assert property (s_mark_reach |=> buffer_event_pending)
    else $error("event not raised at threshold");
  a_mark_zero: assert property (mark == '0 |-> !status_byte[6])
    else $error("level-mark flag with zero threshold");
  a_status_clear: assert property (ld && q.ptr == sfwm_pkg::ADDR_BUF_STATUS && !ev_set
                                   |=> !buffer_event_pending)
    else $error("status read did not clear event");
  a_circ_wrap: assert property ((mode == sfwm_pkg::MODE_CIRC) ##0 s_full_push
                                |=> count == FULL_COUNT && q.ovf)
    else $error("circular overwrite lost count");
  a_stop_drop: assert property ((mode == sfwm_pkg::MODE_STOP) ##0 s_full_push
                                |=> count == FULL_COUNT && $stable(head))
    else $error("stop mode altered contents");
  a_disable_clear: assert property (mode == sfwm_pkg::MODE_OFF
                                    |=> count == '0 && !q.ovf && !status_byte[6])
    else $error("disable did not clear buffer");
  a_active_flush: assert property (active_mode && !q.act_p |=> count == '0)
    else $error("no flush on entering active");
  a_zero_reads: assert property (ld && enabled && q.ptr > sfwm_pkg::ADDR_OUT_FIRST
                                 && q.ptr <= sfwm_pkg::ADDR_OUT_LAST |-> d.shift == '0)
    else $error("unused output byte not zero");
  a_byte_pop: assert property (host_pop && !push_req && !flush
                               |=> count == $past(count) - 1'b1)
    else $error("count not decremented after record");
endmodule

/* File: test_sfwm_top.sv */
`timescale 1ns/1ps

module test_sfwm_top;
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] exp;
  } sfwm_row_t;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic scl;
  logic host_low;
  logic sda_line;
  logic sda_level;
  logic sda_oe;
  logic sample_valid = 1'b0;
  logic sample_ready;
  logic [39:0] sample_data = 40'h0;
  logic [7:0] live_status = 8'h5a;
  logic [39:0] live_data = 40'h1122334455;
  logic active_mode = 1'b1;
  logic buffer_event_pending;
  logic [5:0] stored_sample_count;
  int fail_count = 0;
  int checks = 0;
  logic [39:0] q [$];
  logic [1:0] md = 2'h0;
  logic [5:0] thr = 6'h0;
  logic [7:0] k = 8'h0;
  sfwm_row_t rows [10] = '{'{8'h00, 8'h5a}, '{8'h01, 8'h11}, '{8'h02, 8'h22},
    '{8'h03, 8'h33}, '{8'h04, 8'h44}, '{8'h05, 8'h55}, '{8'h0d, 8'h00},
    '{8'h0e, 8'h00}, '{8'h0f, 8'h00}, '{8'h20, 8'h00}};

  always #12.5 clk = ~clk;

  // Open drain with pull-up: low if anyone pulls
  assign sda_line = ~(host_low | (sda_oe & ~sda_level));

  sfwm_top u_sfwm_top (
    .clk(clk),
    .arst_n(arst_n),
    .scl_pin(scl),
    .sda_pin(sda_line),
    .sda_level(sda_level),
    .sda_oe(sda_oe),
    .sample_valid(sample_valid),
    .sample_ready(sample_ready),
    .sample_data(sample_data),
    .live_status(live_status),
    .live_data(live_data),
    .active_mode(active_mode),
    .buffer_event_pending(buffer_event_pending),
    .stored_sample_count(stored_sample_count)
  );

  sfwm_host u_sfwm_host (
    .scl(scl),
    .sda_low(host_low),
    .sda_line(sda_line)
  );

  task automatic end_of_test();
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  function automatic logic [7:0] stat();
    logic [5:0] n;
    n = 6'(q.size());
    return {n == 6'h20, thr != 6'h0 && n >= thr, n};
  endfunction

  task automatic rd1(input logic [7:0] p, input logic [7:0] e);
    u_sfwm_host.rd_burst(p, 1);
    chk(u_sfwm_host.rd[0], e);
  endtask

  // Model keeps old mode on illegal codes, as the device must
  task automatic setup(input logic [7:0] v);
    u_sfwm_host.wr(8'h0f, v);
    if (v[7:6] != 2'h3 && (md == 2'h0 || v[7:6] == 2'h0 || v[7:6] == md)) md = v[7:6];
    thr = v[5:0];
    if (md == 2'h0) q.delete();
  endtask

  task automatic push(input int n);
    repeat (n) begin
      k++;
      @(negedge clk);
      sample_valid = 1'b1;
      sample_data = {k, k ^ 8'h11, k ^ 8'h22, k ^ 8'h33, k ^ 8'h44};
      if (md != 2'h0 && q.size() < 32) q.push_back(sample_data);
      else if (md == sfwm_pkg::MODE_CIRC) begin
        void'(q.pop_front());
        q.push_back(sample_data);
      end
      @(negedge clk);
      sample_valid = 1'b0;
      @(negedge clk);
      chk({2'h0, stored_sample_count}, 8'(q.size()));
    end
  endtask

  task automatic rec_check();
    logic [39:0] e;
    u_sfwm_host.rd_burst(8'h01, 5);
    e = q.pop_front();
    for (int i = 0; i < 5; i++) chk(u_sfwm_host.rd[i], e[39 - 8 * i -: 8]);
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    chk({2'h0, stored_sample_count}, 8'h00);
    chk({7'h0, buffer_event_pending}, 8'h00);
    chk({7'h0, sample_ready}, 8'h01);
    repeat (4) @(negedge clk);
    foreach (rows[i]) rd1(rows[i].ptr, rows[i].exp);
    u_sfwm_host.rd_burst(8'h00, 7);
    for (int i = 0; i < 7; i++) begin
      chk(u_sfwm_host.rd[i], (i % 6 == 0) ? live_status : live_data[47 - 8 * i -: 8]);
    end
    setup(8'h43);
    rd1(8'h0f, 8'h43);
    push(3);
    chk({7'h0, buffer_event_pending}, 8'h01);
    rd1(8'h0d, stat());
    chk({7'h0, buffer_event_pending}, 8'h00);
    push(1);
    rd1(8'h0d, stat());
    chk({7'h0, buffer_event_pending}, 8'h00);
    // Sample lands mid-transaction; count must not stall
    fork
      rec_check();
      begin
        repeat (100) @(negedge clk);
        push(1);
      end
    join
    chk({2'h0, stored_sample_count}, 8'(q.size()));
    rd1(8'h02, 8'h00);
    push(28);
    // Event follows the registered overflow flag by one cycle
    @(negedge clk);
    chk({7'h0, buffer_event_pending}, 8'h01);
    rd1(8'h0d, stat());
    rd1(8'h0d, stat());
    chk({7'h0, buffer_event_pending}, 8'h00);
    push(2);
    rec_check();
    rd1(8'h0d, stat());
    setup(8'h85);
    rd1(8'h0f, 8'h45);
    setup(8'hc5);
    rd1(8'h0f, 8'h45);
    setup(8'h00);
    rd1(8'h0d, 8'h00);
    chk({2'h0, stored_sample_count}, 8'h00);
    setup(8'h80);
    push(32);
    chk({7'h0, sample_ready}, 8'h00);
    push(1);
    rd1(8'h0d, stat());
    rec_check();
    @(negedge clk);
    active_mode = 1'b0;
    repeat (3) @(negedge clk);
    active_mode = 1'b1;
    repeat (3) @(negedge clk);
    q.delete();
    chk({2'h0, stored_sample_count}, 8'h00);
    chk({7'h0, u_sfwm_host.ack_ok}, 8'h01);
    end_of_test();
  end
endmodule
